//--- hw/smv_pkg.sv
// shared constants and helpers for the mailbox, vector and configuration bank
package smv_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [5:0] SMV_MBOX_CTRL_OFS     = 6'h06;
  localparam logic [5:0] SMV_INBOX_WORD0_OFS   = 6'h08;
  localparam logic [5:0] SMV_INBOX_WORD1_OFS   = 6'h0a;
  localparam logic [5:0] SMV_OUTBOX_WORD0_OFS  = 6'h0c;
  localparam logic [5:0] SMV_OUTBOX_WORD1_OFS  = 6'h0e;
  localparam logic [5:0] SMV_USER_NMI_VEC_OFS  = 6'h1a;
  localparam logic [5:0] SMV_SYS_NMI_VEC_OFS   = 6'h1c;
  localparam logic [5:0] SMV_RESET_VEC_OFS     = 6'h1e;
  localparam logic [5:0] SMV_WR_PROTECT_OFS    = 6'h20;
  localparam logic [5:0] SMV_IR_CFG_OFS        = 6'h22;
  localparam logic [5:0] SMV_ANALOG_SEL_OFS    = 6'h24;

  // ==========================================================================
  // widths and counts
  localparam int SMV_ADDR_W      = 6;
  localparam int SMV_DATA_W      = 16;
  localparam int SMV_MBOX_WORDS  = 4;
  localparam int SMV_USER_NMI_N  = 4;
  localparam int SMV_SYS_NMI_N   = 4;
  localparam int SMV_RST_SRC_N   = 3;
  localparam int SMV_ANALOG_N    = 10;
  localparam int SMV_PEND_W      = 8;

  // ==========================================================================
  // field positions
  localparam int SMV_IN0_FULL_BIT   = 0;
  localparam int SMV_IN1_FULL_BIT   = 1;
  localparam int SMV_OUT0_RDY_BIT   = 2;
  localparam int SMV_OUT1_RDY_BIT   = 3;
  localparam int SMV_WIDTH_SEL_BIT  = 4;
  localparam int SMV_AC_DIS0_BIT    = 6;
  localparam int SMV_AC_DIS1_BIT    = 7;
  localparam int SMV_DATA_LOCK_BIT  = 1;
  localparam int SMV_PROG_LOCK_BIT  = 0;
  localparam int SMV_IR_EN_BIT      = 0;
  localparam int SMV_IR_POL_BIT     = 1;
  localparam int SMV_IR_MOD_BIT     = 2;
  localparam int SMV_IR_SRC_BIT     = 3;
  localparam int SMV_IR_LVL_BIT     = 4;
  localparam int SMV_RST_BOR_IDX    = 0;
  localparam int SMV_RST_POR_IDX    = 1;
  localparam int SMV_RST_PUC_IDX    = 2;

  // ==========================================================================
  // reset values and writable masks
  localparam logic [1:0]  SMV_WR_PROTECT_RST = 2'h3;
  localparam logic [4:0]  SMV_IR_CFG_RST     = 5'h00;
  localparam logic [9:0]  SMV_ANALOG_SEL_RST = 10'h000;
  localparam logic [2:0]  SMV_RST_PEND_RST   = 3'h1;
  localparam logic [1:0]  SMV_OUT_RDY_RST    = 2'h3;
  localparam logic [15:0] SMV_WR_PROTECT_MSK = 16'h0003;
  localparam logic [15:0] SMV_IR_CFG_MSK     = 16'h001f;
  localparam logic [15:0] SMV_ANALOG_SEL_MSK = 16'h03ff;
  localparam logic [15:0] SMV_NO_VEC         = 16'h0000;

  // byte-lane merge: only enabled lanes and writable bits change
  function automatic logic [15:0] smv_merge(input logic [15:0] old_val,
                                            input logic [15:0] new_val,
                                            input logic [1:0]  be,
                                            input logic [15:0] msk);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & msk;
    return (old_val & ~lane) | (new_val & lane);
  endfunction : smv_merge

  // lowest pending index wins; vector is twice the index plus two
  function automatic logic [15:0] smv_vector(input logic [SMV_PEND_W-1:0] pend);
    logic [15:0] v;
    v = SMV_NO_VEC;
    for (int i = SMV_PEND_W - 1; i >= 0; i--) begin
      if (pend[i]) begin
        v = 16'((i + 1) * 2);
      end
    end
    return v;
  endfunction : smv_vector

endpackage : smv_pkg

//--- hw/smv_mbox_mem.sv
// four-word mailbox store with a byte-lane cpu port, a word debug port and two read ports
`timescale 1ns/10ps
module smv_mbox_mem
  import smv_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        a_we_in,
  input  wire logic [1:0]  a_idx_in,
  input  wire logic [1:0]  a_be_in,
  input  wire logic [15:0] a_data_in,
  input  wire logic        b_we_in,
  input  wire logic [1:0]  b_idx_in,
  input  wire logic [15:0] b_data_in,
  input  wire logic [1:0]  ra_idx_in,
  input  wire logic [1:0]  rb_idx_in,
  output logic      [15:0] ra_data_out,
  output logic      [15:0] rb_data_out
);

  typedef struct packed {
    logic [SMV_MBOX_WORDS-1:0][15:0] word;
    logic [15:0]                     ra;
    logic [15:0]                     rb;
  } smv_mem_s;

  smv_mem_s mem_reg;
  smv_mem_s mem_next;

  // ==========================================================================
  // next state: reads sample the old contents, then writes land
  always_comb begin
    mem_next    = mem_reg;
    mem_next.ra = mem_reg.word[ra_idx_in];
    mem_next.rb = mem_reg.word[rb_idx_in];
    if (b_we_in) begin
      mem_next.word[b_idx_in] = b_data_in;
    end
    // cpu lanes applied last; main never aims both ports at one word
    if (a_we_in) begin
      mem_next.word[a_idx_in] = smv_merge(mem_reg.word[a_idx_in], a_data_in, a_be_in,
                                          16'hffff);
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_reg <= '0;
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign ra_data_out = mem_reg.ra;
  assign rb_data_out = mem_reg.rb;

endmodule : smv_mbox_mem

//--- hw/smv_regs.sv
// mailbox, nmi and reset vector generators and system configuration registers
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module smv_regs
  import smv_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,

  // cpu register port
  input  wire logic [SMV_ADDR_W-1:0]     addr_in,
  input  wire logic [15:0]               wdata_in,
  input  wire logic [1:0]                wr_be_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [15:0]               rdata_out,

  // debug port side of the mailboxes
  input  wire logic                      dbg_deposit_in,
  input  wire logic                      dbg_deposit_sel_in,
  input  wire logic [15:0]               dbg_deposit_data_in,
  input  wire logic                      dbg_fetch_in,
  input  wire logic                      dbg_fetch_sel_in,
  output logic      [15:0]               dbg_fetch_data_out,
  output logic      [1:0]                inbox_full_flag_out,
  output logic      [1:0]                outbox_ready_flag_out,
  output logic                           mailbox_width_select_out,

  // interrupt and reset event sources
  input  wire logic [SMV_USER_NMI_N-1:0] user_nmi_event_in,
  input  wire logic [SMV_SYS_NMI_N-1:0]  sys_nmi_event_in,
  input  wire logic                      brownout_reset_event_in,
  input  wire logic                      power_on_reset_event_in,
  input  wire logic                      power_up_clear_event_in,
  output logic                           user_nmi_pending_out,
  output logic                           sys_nmi_pending_out,

  // memory write gating
  input  wire logic                      data_mem_wr_req_in,
  input  wire logic                      program_mem_wr_req_in,
  output logic                           data_mem_write_lock_out,
  output logic                           program_mem_write_lock_out,
  output logic                           data_mem_wr_allow_out,
  output logic                           program_mem_wr_allow_out,

  // infrared modulator configuration
  input  wire logic                      infrared_hw_data_in,
  output logic                           infrared_enable_out,
  output logic                           infrared_polarity_select_out,
  output logic                           infrared_modulation_select_out,
  output logic                           infrared_source_select_out,
  output logic                           infrared_soft_level_out,
  output logic                           infrared_data_out,

  // analog pin selection
  output logic      [SMV_ANALOG_N-1:0]   analog_channel_pin_enable_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    // mailbox flags
    logic [1:0]                in_full;
    logic [1:0]                out_rdy;
    logic                      width_sel;
    logic [1:0]                ac_dis;
    // pending bits
    logic [SMV_USER_NMI_N-1:0] unmi;
    logic [SMV_SYS_NMI_N-1:0]  snmi;
    logic [SMV_RST_SRC_N-1:0]  rst_pend;
    // config words
    logic [1:0]                wp;
    logic [4:0]                ir;
    logic [SMV_ANALOG_N-1:0]   ana;
    // read and pin data
    logic [15:0]               rd;
    logic                      rd_mem;
    logic                      ir_data;
  } smv_state_s;

  smv_state_s st_reg;
  smv_state_s st_next;

  // store steering
  logic [15:0] mem_ra_data;
  logic        mem_a_we;
  logic        mem_b_we;
  logic        mbox_hit;

  // read views
  logic [15:0] ctrl_word;
  logic [15:0] unmi_vec;
  logic [15:0] snmi_vec;
  logic [15:0] rst_vec;
  logic [15:0] wp_word;
  logic [15:0] ir_word;
  logic [15:0] ana_word;

  // helpers
  logic        wr_hi_lane;
  logic        ir_src_level;

  // ==========================================================================
  // read views of the registers
  assign mbox_hit  = (addr_in[SMV_ADDR_W-1:3] == SMV_INBOX_WORD0_OFS[SMV_ADDR_W-1:3]);
  // lowest pending wins
  assign unmi_vec  = smv_vector(SMV_PEND_W'(st_reg.unmi));
  assign snmi_vec  = smv_vector(SMV_PEND_W'(st_reg.snmi));
  assign rst_vec   = smv_vector(SMV_PEND_W'(st_reg.rst_pend));
  // reserved bits read zero
  assign wp_word   = 16'(st_reg.wp);
  assign ir_word   = 16'(st_reg.ir);
  assign ana_word  = 16'(st_reg.ana);
  // releases an outbox word
  assign wr_hi_lane = wr_be_in[1];

  // control word mirrors the mailbox flags and mode bits
  always_comb begin
    // reserved bits zero
    ctrl_word                    = 16'h0000;
    ctrl_word[SMV_IN0_FULL_BIT]  = st_reg.in_full[0];
    ctrl_word[SMV_IN1_FULL_BIT]  = st_reg.in_full[1];
    ctrl_word[SMV_OUT0_RDY_BIT]  = st_reg.out_rdy[0];
    ctrl_word[SMV_OUT1_RDY_BIT]  = st_reg.out_rdy[1];
    ctrl_word[SMV_WIDTH_SEL_BIT] = st_reg.width_sel;
    ctrl_word[SMV_AC_DIS0_BIT]   = st_reg.ac_dis[0];
    ctrl_word[SMV_AC_DIS1_BIT]   = st_reg.ac_dis[1];
  end

  // ==========================================================================
  // mailbox store port steering
  // cpu may only write the outbox half; inbox words stay read-only
  assign mem_a_we = wr_in && mbox_hit && addr_in[2];

  // narrow mode ignores deposits into the second inbox word
  assign mem_b_we = dbg_deposit_in &&
                    (!dbg_deposit_sel_in || st_reg.width_sel);

  // a: cpu, b: debug port
  smv_mbox_mem u_mbox_mem (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .a_we_in     (mem_a_we),
    .a_idx_in    (addr_in[2:1]),
    .a_be_in     (wr_be_in),
    .a_data_in   (wdata_in),
    .b_we_in     (mem_b_we),
    .b_idx_in    ({1'b0, dbg_deposit_sel_in}),
    .b_data_in   (dbg_deposit_data_in),
    .ra_idx_in   (addr_in[2:1]),
    .rb_idx_in   ({1'b1, dbg_fetch_sel_in}),
    .ra_data_out (mem_ra_data),
    .rb_data_out (dbg_fetch_data_out)
  );

  // ==========================================================================
  // next state
  always_comb begin
    // hold by default
    st_next        = st_reg;
    // one-cycle read data
    st_next.rd     = 16'h0000;
    st_next.rd_mem = 1'b0;

    // ------------------------------------------------------------------------
    // cpu reads: data stands only in the cycle after the strobe
    if (rd_in) begin
      st_next.rd_mem = mbox_hit;
      case (addr_in)
        SMV_MBOX_CTRL_OFS:    st_next.rd = ctrl_word;
        SMV_USER_NMI_VEC_OFS: st_next.rd = unmi_vec;
        SMV_SYS_NMI_VEC_OFS:  st_next.rd = snmi_vec;
        SMV_RESET_VEC_OFS:    st_next.rd = rst_vec;
        SMV_WR_PROTECT_OFS:   st_next.rd = wp_word;
        SMV_IR_CFG_OFS:       st_next.rd = ir_word;
        SMV_ANALOG_SEL_OFS:   st_next.rd = ana_word;
        default:              st_next.rd = 16'h0000;
      endcase
      // reading an inbox word drops its flag unless auto-clear is off
      if (addr_in == SMV_INBOX_WORD0_OFS && !st_reg.ac_dis[0]) begin
        st_next.in_full[0] = 1'b0;
      end
      if (addr_in == SMV_INBOX_WORD1_OFS && !st_reg.ac_dis[1]) begin
        st_next.in_full[1] = 1'b0;
      end
    end

    // ------------------------------------------------------------------------
    // cpu writes; odd addresses alias their even word, lanes pick the byte
    if (wr_in) begin
      case ({addr_in[SMV_ADDR_W-1:1], 1'b0})
        SMV_MBOX_CTRL_OFS: begin
          // low lane only
          if (wr_be_in[0]) begin
            // software may clear inbox flags, never set them
            st_next.in_full[0] = st_reg.in_full[0] & wdata_in[SMV_IN0_FULL_BIT];
            st_next.in_full[1] = st_reg.in_full[1] & wdata_in[SMV_IN1_FULL_BIT];
            st_next.width_sel  = wdata_in[SMV_WIDTH_SEL_BIT];
            st_next.ac_dis[0]  = wdata_in[SMV_AC_DIS0_BIT];
            st_next.ac_dis[1]  = wdata_in[SMV_AC_DIS1_BIT];
          end
        end
        SMV_OUTBOX_WORD0_OFS: begin
          if (wr_hi_lane) begin
            st_next.out_rdy[0] = 1'b0;
          end
        end
        SMV_OUTBOX_WORD1_OFS: begin
          if (wr_hi_lane) begin
            st_next.out_rdy[1] = 1'b0;
          end
        end
        // data is ignored
        SMV_USER_NMI_VEC_OFS: st_next.unmi = '0;
        SMV_SYS_NMI_VEC_OFS:  st_next.snmi = '0;
        SMV_RESET_VEC_OFS:    st_next.rst_pend = '0;
        // merge lane by lane
        SMV_WR_PROTECT_OFS: begin
          st_next.wp = 2'(smv_merge(wp_word, wdata_in, wr_be_in,
                                    SMV_WR_PROTECT_MSK));
        end
        SMV_IR_CFG_OFS: begin
          st_next.ir = 5'(smv_merge(ir_word, wdata_in, wr_be_in,
                                    SMV_IR_CFG_MSK));
        end
        SMV_ANALOG_SEL_OFS: begin
          st_next.ana = SMV_ANALOG_N'(smv_merge(ana_word, wdata_in, wr_be_in,
                                               SMV_ANALOG_SEL_MSK));
        end
        default: begin
          st_next.rd_mem = st_next.rd_mem;  // unmapped writes are dropped
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // hardware events last so a set beats a clear in the same cycle
    if (mem_b_we) begin
      st_next.in_full[dbg_deposit_sel_in] = 1'b1;
    end

    // narrow mode: a fetch of the second outbox word does not set its ready flag
    if (dbg_fetch_in && (!dbg_fetch_sel_in || st_reg.width_sel)) begin
      st_next.out_rdy[dbg_fetch_sel_in] = 1'b1;
    end

    // events set pending bits
    st_next.unmi = st_next.unmi | user_nmi_event_in;
    st_next.snmi = st_next.snmi | sys_nmi_event_in;
    if (brownout_reset_event_in) begin
      st_next.rst_pend[SMV_RST_BOR_IDX] = 1'b1;
    end
    if (power_on_reset_event_in) begin
      st_next.rst_pend[SMV_RST_POR_IDX] = 1'b1;
    end
    if (power_up_clear_event_in) begin
      st_next.rst_pend[SMV_RST_PUC_IDX] = 1'b1;
    end

    // ------------------------------------------------------------------------
    // infrared data: chosen source, then polarity, forced low when off
    // registered: no pin glitch
    st_next.ir_data = st_reg.ir[SMV_IR_EN_BIT] &
                      (ir_src_level ^ st_reg.ir[SMV_IR_POL_BIT]);
  end

  // software level or hardware peripheral data
  assign ir_src_level = st_reg.ir[SMV_IR_SRC_BIT] ? st_reg.ir[SMV_IR_LVL_BIT]
                                                  : infrared_hw_data_in;

  // ==========================================================================
  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // all zero, then named reset values by field
      st_reg          <= '0;
      st_reg.out_rdy  <= SMV_OUT_RDY_RST;
      st_reg.rst_pend <= SMV_RST_PEND_RST;
      st_reg.wp       <= SMV_WR_PROTECT_RST;
      st_reg.ir       <= SMV_IR_CFG_RST;
      st_reg.ana      <= SMV_ANALOG_SEL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs
  // mailbox reads come from the store's own read register
  assign rdata_out = st_reg.rd_mem ? mem_ra_data : st_reg.rd;

  // mailbox levels
  assign inbox_full_flag_out      = st_reg.in_full;
  assign outbox_ready_flag_out    = st_reg.out_rdy;
  assign mailbox_width_select_out = st_reg.width_sel;

  // pending summaries
  assign user_nmi_pending_out     = |st_reg.unmi;
  assign sys_nmi_pending_out      = |st_reg.snmi;

  // locks gate the write requests directly; no latency through the bank
  assign data_mem_write_lock_out    = st_reg.wp[SMV_DATA_LOCK_BIT];
  assign program_mem_write_lock_out = st_reg.wp[SMV_PROG_LOCK_BIT];
  assign data_mem_wr_allow_out      = data_mem_wr_req_in &&
                                      !st_reg.wp[SMV_DATA_LOCK_BIT];
  assign program_mem_wr_allow_out   = program_mem_wr_req_in &&
                                      !st_reg.wp[SMV_PROG_LOCK_BIT];

  // infrared config bits
  assign infrared_enable_out            = st_reg.ir[SMV_IR_EN_BIT];
  assign infrared_polarity_select_out   = st_reg.ir[SMV_IR_POL_BIT];
  assign infrared_modulation_select_out = st_reg.ir[SMV_IR_MOD_BIT];
  assign infrared_source_select_out     = st_reg.ir[SMV_IR_SRC_BIT];
  assign infrared_soft_level_out        = st_reg.ir[SMV_IR_LVL_BIT];
  assign infrared_data_out              = st_reg.ir_data;

  // analog pin enables
  assign analog_channel_pin_enable_out = st_reg.ana;

endmodule : smv_regs

//--- verif/smv_regs_asserts.sv
// port-level checks for the mailbox, vector and configuration bank
`timescale 1ns/10ps
module smv_regs_asserts
  import smv_pkg::*;
(
  input wire logic                      clk_in,
  input wire logic                      resetn_in,
  input wire logic [SMV_ADDR_W-1:0]     addr_in,
  input wire logic [15:0]               wdata_in,
  input wire logic [1:0]                wr_be_in,
  input wire logic                      wr_in,
  input wire logic                      rd_in,
  input wire logic [15:0]               rdata_out,
  input wire logic                      dbg_deposit_in,
  input wire logic                      dbg_deposit_sel_in,
  input wire logic [15:0]               dbg_deposit_data_in,
  input wire logic                      dbg_fetch_in,
  input wire logic                      dbg_fetch_sel_in,
  input wire logic [1:0]                inbox_full_flag_out,
  input wire logic [1:0]                outbox_ready_flag_out,
  input wire logic [SMV_USER_NMI_N-1:0] user_nmi_event_in,
  input wire logic                      user_nmi_pending_out,
  input wire logic                      data_mem_wr_req_in,
  input wire logic                      data_mem_write_lock_out,
  input wire logic                      data_mem_wr_allow_out,
  input wire logic [SMV_ANALOG_N-1:0]   analog_channel_pin_enable_out
);
  // ==========================================================================
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_dep0; dbg_deposit_in && !dbg_deposit_sel_in; endsequence
  property p_cfg0_rsvd; rd_in && addr_in == SMV_WR_PROTECT_OFS
    |=> rdata_out[15:2] == 14'h0; endproperty
  a_cfg0_rsvd: assert property (p_cfg0_rsvd) else $error("reserved bits read nonzero");
  property p_lock; wr_in && addr_in == SMV_WR_PROTECT_OFS && wr_be_in[0]
    |=> data_mem_write_lock_out == $past(wdata_in[1]); endproperty
  a_lock: assert property (p_lock) else $error("data lock not written");
  property p_allow;
    data_mem_wr_allow_out == (data_mem_wr_req_in && !data_mem_write_lock_out); endproperty
  a_allow: assert property (p_allow) else $error("data write gate wrong");
  property p_ana; wr_in && addr_in == SMV_ANALOG_SEL_OFS && wr_be_in == 2'h3
    |=> analog_channel_pin_enable_out == $past(wdata_in[9:0]); endproperty
  a_ana: assert property (p_ana) else $error("analog select not written");
  property p_ana_keep; wr_in && addr_in == SMV_ANALOG_SEL_OFS && wr_be_in == 2'h2
    |=> $stable(analog_channel_pin_enable_out[7:0]); endproperty
  a_ana_keep: assert property (p_ana_keep) else $error("low byte changed");
  property p_unmi_clr; wr_in && addr_in == SMV_USER_NMI_VEC_OFS && user_nmi_event_in == '0
    |=> !user_nmi_pending_out; endproperty
  a_unmi_clr: assert property (p_unmi_clr) else $error("user nmi not cleared");
  property p_unmi_set; |user_nmi_event_in |=> user_nmi_pending_out; endproperty
  a_unmi_set: assert property (p_unmi_set) else $error("user nmi not pending");
  property p_in_flag; s_dep0 |=> inbox_full_flag_out[0]; endproperty
  a_in_flag: assert property (p_in_flag) else $error("inbox flag not set");
  property p_in_data; s_dep0 ##2 (rd_in && addr_in == SMV_INBOX_WORD0_OFS)
    |=> rdata_out == $past(dbg_deposit_data_in, 3); endproperty
  a_in_data: assert property (p_in_data) else $error("inbox word wrong");
  property p_out_rdy; wr_in && addr_in == SMV_OUTBOX_WORD0_OFS && wr_be_in[1]
    && !(dbg_fetch_in && !dbg_fetch_sel_in) |=> !outbox_ready_flag_out[0]; endproperty
  a_out_rdy: assert property (p_out_rdy) else $error("outbox ready not cleared");
endmodule : smv_regs_asserts

//--- verif/smv_dbg_model.sv
// debug-port side model: deposits inbox words, fetches outbox words
`timescale 1ns/10ps
module smv_dbg_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] fetch_data_in,
  output logic             dep_out,
  output logic             dep_sel_out,
  output logic      [15:0] dep_data_out,
  output logic             fetch_out,
  output logic             fetch_sel_out
);
  // ==========================================================================
  // idle state, then one-cycle pulses; data inverted after use so stale words never match
  initial begin
    {dep_out, dep_sel_out, fetch_out, fetch_sel_out, dep_data_out} = '0;
  end
  task automatic deposit(input logic s, input logic [15:0] v);
    @(posedge clk_in);
    {dep_out, dep_sel_out, dep_data_out} <= {1'b1, s, v};
    @(posedge clk_in);
    {dep_out, dep_data_out} <= {1'b0, ~v};
  endtask : deposit
  // select first, read the registered word, then report it taken
  task automatic fetch(input logic s, output logic [15:0] v);
    @(posedge clk_in);
    fetch_sel_out <= s;
    @(posedge clk_in);
    #1 v = fetch_data_in;
    @(posedge clk_in);
    fetch_out <= 1'b1;
    @(posedge clk_in);
    fetch_out <= 1'b0;
  endtask : fetch
endmodule : smv_dbg_model

//--- verif/smv_regs_test.sv
// self-checking bench for the mailbox, vector and configuration bank
`timescale 1ns/10ps
module smv_regs_test;
  import smv_pkg::*;
  logic        clk_in, resetn_in, wr_in, rd_in, dbg_deposit_in, dbg_deposit_sel_in;
  logic        dbg_fetch_in, dbg_fetch_sel_in, mailbox_width_select_out;
  logic        user_nmi_pending_out, sys_nmi_pending_out, infrared_hw_data_in;
  logic        brownout_reset_event_in, power_on_reset_event_in, power_up_clear_event_in;
  logic        data_mem_wr_req_in, program_mem_wr_req_in, infrared_data_out;
  logic        data_mem_write_lock_out, program_mem_write_lock_out;
  logic        data_mem_wr_allow_out, program_mem_wr_allow_out, infrared_enable_out;
  logic        infrared_polarity_select_out, infrared_modulation_select_out;
  logic        infrared_source_select_out, infrared_soft_level_out;
  logic [5:0]  addr_in;
  logic [15:0] wdata_in, rdata_out, dbg_deposit_data_in, dbg_fetch_data_out, d;
  logic [1:0]  wr_be_in, inbox_full_flag_out, outbox_ready_flag_out;
  logic [3:0]  user_nmi_event_in, sys_nmi_event_in;
  logic [9:0]  analog_channel_pin_enable_out;
  logic [5:0]  ra[11] = '{6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h1a, 6'h1c, 6'h1e, 6'h20, 6'h22,
    6'h24, 6'h30};
  logic [15:0] rv[11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2, 16'h3, 16'h0,
    16'h0, 16'h0};
  int          n_errors = 0;
  int          checks_done = 0;
  smv_regs dut (.*);
  smv_dbg_model dbg (.clk_in, .fetch_data_in(dbg_fetch_data_out), .dep_out(dbg_deposit_in),
    .dep_sel_out(dbg_deposit_sel_in), .dep_data_out(dbg_deposit_data_in),
    .fetch_out(dbg_fetch_in), .fetch_sel_out(dbg_fetch_sel_in));
  // ==========================================================================
  // bus tasks: strobes set after an edge, dropped after the taking edge
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] v, input logic [1:0] be = 2'h3);
    @(posedge clk_in);
    {wr_in, addr_in, wdata_in, wr_be_in} <= {1'b1, a, v, be};
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    {rd_in, addr_in} <= {1'b1, a};
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rd
  // event pulse: user nmi, system nmi, brownout, power-on, power-up clear
  task automatic ev(input logic [10:0] v);
    @(posedge clk_in);
    {user_nmi_event_in, sys_nmi_event_in, brownout_reset_event_in,
      power_on_reset_event_in, power_up_clear_event_in} <= v;
    @(posedge clk_in);
    {user_nmi_event_in, sys_nmi_event_in, brownout_reset_event_in,
      power_on_reset_event_in, power_up_clear_event_in} <= '0;
  endtask : ev
  task automatic give_verdict();
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // clock, watchdog far beyond the roughly 110 cycles needed, main sequence
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    n_errors++;
    give_verdict();
  end
  initial begin
    {wr_in, rd_in, addr_in, wdata_in, wr_be_in, user_nmi_event_in, sys_nmi_event_in} = '0;
    {brownout_reset_event_in, power_on_reset_event_in, power_up_clear_event_in} = '0;
    {data_mem_wr_req_in, program_mem_wr_req_in, infrared_hw_data_in, resetn_in} = 4'he;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b0 | 1'b1;
    for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
    chk(16'({inbox_full_flag_out, outbox_ready_flag_out, data_mem_wr_allow_out,
      program_mem_write_lock_out}), 16'hd);
    wr(6'h20, 16'hffff);
    rd(6'h20, 16'h0003);
    wr(6'h20, 16'h0000, 2'h1);
    #1 chk(16'({data_mem_wr_allow_out, program_mem_wr_allow_out}), 16'h3);
    wr(6'h24, 16'hffff);
    wr(6'h24, 16'h0000, 2'h2);
    rd(6'h24, 16'h00ff);
    wr(6'h22, 16'hffff);
    rd(6'h22, 16'h001f);
    wr(6'h22, 16'h0019);
    #1 chk(16'({infrared_soft_level_out, infrared_source_select_out,
      infrared_modulation_select_out, infrared_polarity_select_out, infrared_enable_out}), 16'h19);
    @(posedge clk_in);
    #1 chk(16'(infrared_data_out), 16'h1);
    wr(6'h22, 16'h0003);
    @(posedge clk_in);
    #1 chk(16'(infrared_data_out), 16'h0);
    wr(6'h08, 16'hffff);
    dbg.deposit(1'b0, 16'h1234);
    #1 chk(16'(inbox_full_flag_out), 16'h1);
    rd(6'h08, 16'h1234);
    chk(16'(inbox_full_flag_out), 16'h0);
    dbg.deposit(1'b1, 16'h5678);
    #1 chk(16'(inbox_full_flag_out), 16'h0);
    wr(6'h06, 16'h0010);
    rd(6'h06, 16'h001c);
    dbg.deposit(1'b1, 16'h5678);
    rd(6'h0a, 16'h5678);
    wr(6'h06, 16'h0050);
    dbg.deposit(1'b0, 16'h9abc);
    rd(6'h08, 16'h9abc);
    chk(16'(inbox_full_flag_out), 16'h1);
    wr(6'h0c, 16'habcd);
    #1 chk(16'(outbox_ready_flag_out), 16'h2);
    dbg.fetch(1'b0, d);
    chk(d, 16'habcd);
    #1 chk(16'(outbox_ready_flag_out), 16'h3);
    ev(11'h200);
    rd(6'h1a, 16'h0006);
    wr(6'h1a, 16'h0000);
    rd(6'h1a, 16'h0000);
    ev(11'h030);
    rd(6'h1c, 16'h0004);
    chk(16'({sys_nmi_pending_out, mailbox_width_select_out}), 16'h3);
    wr(6'h1c, 16'hffff);
    rd(6'h1c, 16'h0000);
    wr(6'h1e, 16'h0000);
    rd(6'h1e, 16'h0000);
    ev(11'h003);
    rd(6'h1e, 16'h0004);
    give_verdict();
  end
endmodule : smv_regs_test
bind smv_regs smv_regs_asserts chk_i (.*);
